/* adfr_ctrl.sv */
// Main controller: straps, door lamps, compressor fan delay, relays, displays.
// Assumes temperature inputs are already digitised on clk_i; door and strap
// pins are asynchronous and are synchronised here.
//
// Functional notes
// - Open door shows the measured temperature instead of the setpoint.
// - Shown actual clamps to -35..30 freezer, -9..9 refrigerator.
// - Freezer above 0 C for 10 minutes makes its display blink.
// - Refrigerator above 15 C for 10 minutes makes its display blink.
// - Door open steps shown value up 1 C per delay; close steps down.
// - Defrost start shows setpoints and blocks blinking for two hours.
// - Compressor restart with ambient 5 C or less keeps fan off.
// - Fan delay 9, 6 or 3 minutes for ambient 6-10, 11-15, 16-21.
// - Ambient above 21 C turns the fan on at once.
// - Low door input means open; lamp relay driven high.
// - High door input means closed; lamp relay driven low.
// - Loads run while their relay output is high, stop when low.
// - Defrost heaters powered only while compressor relay is released.
// - Straps are sampled once after each reset and then ignored.
// - Freezer strap code maps to shifts 0,-0.5,-1,-2,-3,+1,+2,+3.
// - Refrigerator strap code uses same map and offsets its setpoint.
`timescale 1ns/1ps
module adfr_ctrl import adfr_pkg::*; #(
  parameter int unsigned TICK_DIV = TICK_CYCLES,
  parameter int unsigned STEP_DELAY_SEC = STEP_DELAY_SEC_DEF
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic freezer_door_n_i,
  input wire logic fridge_door_n_i,
  input wire logic freezer_shift_strap_hi_i,
  input wire logic freezer_shift_strap_mid_i,
  input wire logic freezer_shift_strap_lo_i,
  input wire logic fridge_shift_strap_hi_i,
  input wire logic fridge_shift_strap_mid_i,
  input wire logic fridge_shift_strap_lo_i,
  input wire adfr_temps_t temps_i,
  input wire logic signed [7:0] freezer_set_i,
  input wire logic signed [7:0] fridge_set_i,
  input wire logic comp_req_i,
  input wire logic freezer_defrost_req_i,
  input wire logic fridge_defrost_req_i,
  input wire logic defrost_start_i,
  output adfr_relays_t relays_o,
  output logic signed [7:0] freezer_shown_o,
  output logic signed [7:0] fridge_shown_o,
  output logic freezer_actual_o,
  output logic fridge_actual_o,
  output logic freezer_blink_o,
  output logic fridge_blink_o,
  output logic signed [8:0] freezer_set_half_o,
  output logic signed [8:0] fridge_set_half_o
);
  // Elaboration checks: refuse values the counters cannot hold
  if (TICK_DIV < 1) begin : g_bad_div
    $error("adfr_ctrl: TICK_DIV must be at least one");
  end
  if (STEP_DELAY_SEC < 1) begin : g_bad_step
    $error("adfr_ctrl: STEP_DELAY_SEC must be at least one");
  end
  // The channels count step, warm and hold seconds in 16 bits
  if (STEP_DELAY_SEC > 65536) begin : g_big_step
    $error("adfr_ctrl: STEP_DELAY_SEC exceeds the 16-bit step counter");
  end
  if (DEFROST_HOLD_SEC > 65535 || BLINK_SEC > 65536) begin : g_big_hold
    $error("adfr_ctrl: blink or defrost hold exceeds 16-bit counters");
  end
  if (FAN_LONG_SEC > 65535) begin : g_big_fan
    $error("adfr_ctrl: fan delay exceeds the 16-bit fan counter");
  end

  // Two-flop synchronisers for door and strap pins; they reset to the
  // closed-door level so the lamps stay dark while they fill
  logic [7:0] pin_raw;
  logic [7:0] pin_s1_q;
  logic [7:0] pin_s2_q;
  assign pin_raw = {freezer_door_n_i, fridge_door_n_i,
                    freezer_shift_strap_hi_i, freezer_shift_strap_mid_i,
                    freezer_shift_strap_lo_i, fridge_shift_strap_hi_i,
                    fridge_shift_strap_mid_i, fridge_shift_strap_lo_i};

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pin_s1_q <= 8'hff;
      pin_s2_q <= 8'hff;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
    end
  end

  // One-second prescaler; every minute and hour count rides on this tick,
  // so those delays are exact to within one second
  logic [31:0] pre_cnt_q;
  logic tick_q;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pre_cnt_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else if (pre_cnt_q >= 32'(TICK_DIV - 1)) begin
      pre_cnt_q <= 32'h0000_0000;
      tick_q <= 1'b1;
    end else begin
      pre_cnt_q <= pre_cnt_q + 32'h0000_0001;
      tick_q <= 1'b0;
    end
  end

  // Strap capture: wait until the synchroniser holds post-reset pin values;
  // a strap moved while running is never looked at again
  logic [1:0] strap_wait_q;
  logic strap_done_q;
  logic [2:0] frz_code_q;
  logic [2:0] frg_code_q;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      strap_wait_q <= 2'h0;
    end else if (strap_wait_q != 2'h2) begin
      strap_wait_q <= strap_wait_q + 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      strap_done_q <= 1'b0;
      frz_code_q <= 3'h0;
      frg_code_q <= 3'h0;
    end else if (!strap_done_q && strap_wait_q == 2'h2) begin
      strap_done_q <= 1'b1;
      frz_code_q <= pin_s2_q[5:3];
      frg_code_q <= pin_s2_q[2:0];
    end
  end

  function automatic logic signed [3:0] shift_half(input logic [2:0] code);
    case (code)
      3'h0: shift_half = SHIFT_REF;
      3'h1: shift_half = SHIFT_M05;
      3'h2: shift_half = SHIFT_M10;
      3'h3: shift_half = SHIFT_M20;
      3'h4: shift_half = SHIFT_M30;
      3'h5: shift_half = SHIFT_P10;
      3'h6: shift_half = SHIFT_P20;
      3'h7: shift_half = SHIFT_P30;
      default: shift_half = SHIFT_REF;
    endcase
  endfunction : shift_half

  // Effective setpoints in half degrees, for the temperature regulator;
  // the shift is not clamped, the regulator owns the range of its input
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      freezer_set_half_o <= 9'sh000;
      fridge_set_half_o <= 9'sh000;
    end else begin
      freezer_set_half_o <= 9'({freezer_set_i, 1'b0})
                          + 9'(shift_half(frz_code_q));
      fridge_set_half_o <= 9'({fridge_set_i, 1'b0})
                         + 9'(shift_half(frg_code_q));
    end
  end

  // Compressor cooling fan delay after each compressor restart
  adfr_fan_state_t fan_state_q;
  logic comp_prev_q;
  logic [15:0] fan_cnt_q;
  logic signed [7:0] amb;
  assign amb = temps_i.ambient;

  // A restart is a rising edge of demand; the edge flop idles low like the
  // demand itself, so no false restart follows reset
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      comp_prev_q <= 1'b0;
    end else begin
      comp_prev_q <= comp_req_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      fan_state_q <= ADFR_FAN_IDLE;
      fan_cnt_q <= 16'h0000;
    end else if (!comp_req_i) begin
      fan_state_q <= ADFR_FAN_IDLE;
      fan_cnt_q <= 16'h0000;
    end else begin
      case (fan_state_q)
        ADFR_FAN_IDLE: begin
          if (!comp_prev_q) begin
            if (amb <= AMB_FAN_OFF_MAX) begin
              fan_state_q <= ADFR_FAN_IDLE;
            end else if (amb > AMB_SHORT_MAX) begin
              fan_state_q <= ADFR_FAN_ON;
            end else begin
              fan_state_q <= ADFR_FAN_WAIT;
              if (amb <= AMB_LONG_MAX) fan_cnt_q <= 16'(FAN_LONG_SEC);
              else if (amb <= AMB_MID_MAX) fan_cnt_q <= 16'(FAN_MID_SEC);
              else fan_cnt_q <= 16'(FAN_SHORT_SEC);
            end
          end
        end
        ADFR_FAN_WAIT: begin
          // The first counted second may be short by part of a tick
          if (tick_q) begin
            if (fan_cnt_q <= 16'h0001) begin
              fan_state_q <= ADFR_FAN_ON;
              fan_cnt_q <= 16'h0000;
            end else begin
              fan_cnt_q <= fan_cnt_q - 16'h0001;
            end
          end
        end
        ADFR_FAN_ON: fan_state_q <= ADFR_FAN_ON;
        default: fan_state_q <= ADFR_FAN_IDLE;
      endcase
    end
  end

  // Relay drivers, one flop per load, gathered into relays_o below
  logic comp_rly_q;
  logic fan_rly_q;
  logic frz_def_rly_q;
  logic frg_def_rly_q;
  logic frz_lamp_rly_q;
  logic frg_lamp_rly_q;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      comp_rly_q <= 1'b0;
      fan_rly_q <= 1'b0;
    end else begin
      comp_rly_q <= comp_req_i;
      fan_rly_q <= comp_req_i && fan_state_q == ADFR_FAN_ON;
    end
  end

  // The heaters take the inverse of the very demand that drives the
  // compressor flop, so both can never be energised in one cycle
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      frz_def_rly_q <= 1'b0;
      frg_def_rly_q <= 1'b0;
    end else begin
      frz_def_rly_q <= freezer_defrost_req_i && !comp_req_i;
      frg_def_rly_q <= fridge_defrost_req_i && !comp_req_i;
    end
  end

  // Lamps follow the synchronised door pins; a low pin is an open door,
  // and the pins reset high so no lamp flashes as reset is released
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      frz_lamp_rly_q <= 1'b0;
      frg_lamp_rly_q <= 1'b0;
    end else begin
      frz_lamp_rly_q <= !pin_s2_q[7];
      frg_lamp_rly_q <= !pin_s2_q[6];
    end
  end

  assign relays_o = '{compressor: comp_rly_q,
                      comp_fan: fan_rly_q,
                      freezer_defrost: frz_def_rly_q,
                      fridge_defrost: frg_def_rly_q,
                      freezer_lamp: frz_lamp_rly_q,
                      fridge_lamp: frg_lamp_rly_q};

  // Display channels
  logic signed [7:0] frz_shown;
  logic signed [7:0] frg_shown;
  logic frz_act;
  logic frg_act;
  logic frz_blink;
  logic frg_blink;

  adfr_disp_chan #(
    .SHOW_MIN(FRZ_SHOW_MIN),
    .SHOW_MAX(FRZ_SHOW_MAX),
    .WARM_LIMIT(FRZ_WARM_LIMIT),
    .STEP_DELAY_SEC(STEP_DELAY_SEC)
  ) u_freezer_disp (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .tick_i(tick_q),
    .door_open_i(!pin_s2_q[7]),
    .defrost_start_i(defrost_start_i),
    .actual_i(temps_i.freezer),
    .setpoint_i(freezer_set_i),
    .shown_o(frz_shown),
    .show_actual_o(frz_act),
    .blink_o(frz_blink)
  );

  adfr_disp_chan #(
    .SHOW_MIN(FRG_SHOW_MIN),
    .SHOW_MAX(FRG_SHOW_MAX),
    .WARM_LIMIT(FRG_WARM_LIMIT),
    .STEP_DELAY_SEC(STEP_DELAY_SEC)
  ) u_fridge_disp (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .tick_i(tick_q),
    .door_open_i(!pin_s2_q[6]),
    .defrost_start_i(defrost_start_i),
    .actual_i(temps_i.fridge),
    .setpoint_i(fridge_set_i),
    .shown_o(frg_shown),
    .show_actual_o(frg_act),
    .blink_o(frg_blink)
  );

  // Register the display outputs so every top output is a flop
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      freezer_shown_o <= 8'sh00;
      freezer_actual_o <= 1'b0;
      freezer_blink_o <= 1'b0;
    end else begin
      freezer_shown_o <= frz_shown;
      freezer_actual_o <= frz_act;
      freezer_blink_o <= frz_blink;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      fridge_shown_o <= 8'sh00;
      fridge_actual_o <= 1'b0;
      fridge_blink_o <= 1'b0;
    end else begin
      fridge_shown_o <= frg_shown;
      fridge_actual_o <= frg_act;
      fridge_blink_o <= frg_blink;
    end
  end
endmodule : adfr_ctrl

/* adfr_ctrl_props.sv */
// Port checker for the display, fan and relay controller.
// Assumes it is bound to adfr_ctrl and sees its ports only.
`timescale 1ns/1ps
module adfr_ctrl_props import adfr_pkg::*; (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic freezer_door_n_i,
  input wire logic fridge_door_n_i,
  input wire adfr_temps_t temps_i,
  input wire logic comp_req_i,
  input wire logic defrost_start_i,
  input wire adfr_relays_t relays_o,
  input wire logic signed [7:0] freezer_shown_o,
  input wire logic freezer_actual_o,
  input wire logic freezer_blink_o,
  input wire logic fridge_blink_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Five edges of rest cover the two synchroniser flops
  frz_lamp_on_a: assert property (
    (!freezer_door_n_i) [*5] |-> relays_o.freezer_lamp)
    else $error("freezer lamp off with door open");
  frz_lamp_off_a: assert property (
    freezer_door_n_i [*5] |-> !relays_o.freezer_lamp)
    else $error("freezer lamp on with door shut");
  frg_lamp_on_a: assert property (
    (!fridge_door_n_i) [*5] |-> relays_o.fridge_lamp)
    else $error("fridge lamp off with door open");
  comp_follow_a: assert property (
    !$past(reset_i) |-> relays_o.compressor == $past(comp_req_i))
    else $error("compressor relay not following demand");
  heater_lock_a: assert property (
    comp_req_i |=> !relays_o.freezer_defrost && !relays_o.fridge_defrost)
    else $error("defrost relay on with compressor");
  fan_cold_a: assert property (
    $rose(comp_req_i) && temps_i.ambient <= AMB_FAN_OFF_MAX
    |=> (!relays_o.comp_fan) [*8]) else $error("fan on when cold");
  fan_wait_a: assert property (
    $rose(comp_req_i) && temps_i.ambient > AMB_FAN_OFF_MAX &&
    temps_i.ambient <= AMB_SHORT_MAX |=> (!relays_o.comp_fan) [*8])
    else $error("fan on before its delay");
  fan_hot_a: assert property (
    $rose(comp_req_i) && temps_i.ambient > AMB_SHORT_MAX
    |-> ##[1:3] relays_o.comp_fan) else $error("fan late when hot");
  frz_actual_a: assert property (
    (!freezer_door_n_i) [*6] |-> freezer_actual_o)
    else $error("freezer not showing actual");
  frz_clamp_a: assert property (
    freezer_actual_o |-> freezer_shown_o >= FRZ_SHOW_MIN &&
    freezer_shown_o <= FRZ_SHOW_MAX) else $error("freezer shown out of range");
  frz_cool_a: assert property (
    (temps_i.freezer <= FRZ_WARM_LIMIT) [*3] |-> !freezer_blink_o)
    else $error("freezer blinks while cold");
  defrost_hush_a: assert property (
    defrost_start_i |-> ##3 (!freezer_blink_o && !fridge_blink_o) [*8])
    else $error("blink after defrost start");
endmodule : adfr_ctrl_props

bind adfr_ctrl adfr_ctrl_props u_props (.clk_i(clk_i), .reset_i(reset_i),
  .freezer_door_n_i(freezer_door_n_i), .fridge_door_n_i(fridge_door_n_i),
  .temps_i(temps_i), .comp_req_i(comp_req_i),
  .defrost_start_i(defrost_start_i), .relays_o(relays_o),
  .freezer_shown_o(freezer_shown_o), .freezer_actual_o(freezer_actual_o),
  .freezer_blink_o(freezer_blink_o), .fridge_blink_o(fridge_blink_o));

/* adfr_ctrl_tb.sv */
// Self-checking bench for the display, fan and relay controller.
// Assumes a 100 MHz clock and a one-second tick shortened to ten cycles.
`timescale 1ns/1ps
module adfr_ctrl_tb import adfr_pkg::*;;
  localparam int TDIV = 10;
  localparam int LIMIT = 60000;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic frz_open = 1'b0;
  logic frg_open = 1'b0;
  logic [2:0] frz_code = 3'h0;
  logic [2:0] frg_code = 3'h0;
  adfr_temps_t temps = {-8'sd18, 8'sd3, 8'sd25};
  logic signed [7:0] frz_set = -8'sd18;
  logic signed [7:0] frg_set = 8'sd3;
  logic comp_req = 1'b0;
  logic frz_def = 1'b0;
  logic frg_def = 1'b0;
  logic def_start = 1'b0;
  logic frz_door_n;
  logic frg_door_n;
  logic [5:0] straps;
  adfr_relays_t relays;
  logic signed [7:0] frz_shown;
  logic signed [7:0] frg_shown;
  logic frz_act;
  logic frg_act;
  logic frz_blink;
  logic frg_blink;
  logic signed [8:0] frz_half;
  logic signed [8:0] frg_half;
  int bad_count = 0;
  int checks = 0;
  int cycles = 0;
  int shift_half [8] = '{0, -1, -2, -4, -6, 2, 4, 6};

  adfr_env u_env (.freezer_open_i(frz_open), .fridge_open_i(frg_open),
    .frz_code_i(frz_code), .frg_code_i(frg_code),
    .freezer_door_n_o(frz_door_n), .fridge_door_n_o(frg_door_n),
    .straps_o(straps));
  adfr_ctrl #(.TICK_DIV(TDIV), .STEP_DELAY_SEC(2)) dut (
    .clk_i(clk_i), .reset_i(reset_i),
    .freezer_door_n_i(frz_door_n), .fridge_door_n_i(frg_door_n),
    .freezer_shift_strap_hi_i(straps[5]),
    .freezer_shift_strap_mid_i(straps[4]),
    .freezer_shift_strap_lo_i(straps[3]),
    .fridge_shift_strap_hi_i(straps[2]),
    .fridge_shift_strap_mid_i(straps[1]),
    .fridge_shift_strap_lo_i(straps[0]),
    .temps_i(temps), .freezer_set_i(frz_set), .fridge_set_i(frg_set),
    .comp_req_i(comp_req), .freezer_defrost_req_i(frz_def),
    .fridge_defrost_req_i(frg_def), .defrost_start_i(def_start),
    .relays_o(relays), .freezer_shown_o(frz_shown),
    .fridge_shown_o(frg_shown), .freezer_actual_o(frz_act),
    .fridge_actual_o(frg_act), .freezer_blink_o(frz_blink),
    .fridge_blink_o(frg_blink), .freezer_set_half_o(frz_half),
    .fridge_set_half_o(frg_half));

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  task automatic summarize();
    if (bad_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  // A hung wait must still reach the verdict
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      bad_count = bad_count + 1;
      summarize();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  task automatic chk_b(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_b

  task automatic chk_v(input string what, input logic signed [8:0] exp,
                       input logic signed [8:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_v

  task automatic do_reset(input int n);
    reset_i = 1'b1;
    tick(n);
    reset_i = 1'b0;
    tick(6);
  endtask : do_reset

  task automatic wait_frz(input int lim);
    logic signed [7:0] s;
    s = frz_shown;
    for (int i = 0; i < lim && frz_shown === s; i++) tick(1);
  endtask : wait_frz

  task automatic t_straps();
    for (int c = 0; c < 8; c++) begin
      frz_code = c[2:0];
      frg_code = 3'h7 - c[2:0];
      do_reset(2);
      chk_v("frz half", 9'(2 * frz_set + shift_half[c]), frz_half);
      chk_v("frg half", 9'(2 * frg_set + shift_half[7-c]), frg_half);
      frz_code = ~frz_code;
      frg_code = ~frg_code;
      tick(5);
      chk_v("frz held", 9'(2 * frz_set + shift_half[c]), frz_half);
    end
  endtask : t_straps

  task automatic t_doors();
    temps.freezer = -8'sd10;
    temps.fridge = 8'sd20;
    frz_open = 1'b1;
    tick(6);
    chk_b("frz lamp", 1'b1, relays.freezer_lamp);
    chk_b("frg lamp", 1'b0, relays.fridge_lamp);
    chk_b("frz actual", 1'b1, frz_act);
    chk_b("frg actual", 1'b0, frg_act);
    wait_frz(40);
    chk_v("frz step up", -9'sd17, frz_shown);
    frg_open = 1'b1;
    tick(300);
    chk_v("frg clamp", 9'sd9, frg_shown);
    chk_v("frz top", -9'sd10, frz_shown);
    frz_open = 1'b0;
    frg_open = 1'b0;
    tick(6);
    chk_b("frz lamp off", 1'b0, relays.freezer_lamp);
    // Interiors cool again; shown values follow them down to the setpoints
    temps.freezer = frz_set;
    temps.fridge = frg_set;
    wait_frz(40);
    chk_v("frz step down", -9'sd11, frz_shown);
    tick(300);
    chk_v("frz at set", 9'(frz_set), frz_shown);
    chk_b("frz actual off", 1'b0, frz_act);
  endtask : t_doors

  task automatic t_fan();
    int amb [8] = '{5, 6, 10, 11, 15, 16, 21, 22};
    int sec [8] = '{-1, FAN_LONG_SEC, FAN_LONG_SEC, FAN_MID_SEC,
                    FAN_MID_SEC, FAN_SHORT_SEC, FAN_SHORT_SEC, 0};
    int n;
    int lo;
    int hi;
    for (int k = 0; k < 8; k++) begin
      temps.ambient = 8'(amb[k]);
      comp_req = 1'b0;
      tick(3);
      comp_req = 1'b1;
      n = 0;
      lo = sec[k] * TDIV - TDIV;
      hi = sec[k] * TDIV + TDIV + 4;
      while (n < 6000 && relays.comp_fan !== 1'b1) begin
        tick(1);
        n++;
      end
      chk_b("compressor", 1'b1, relays.compressor);
      if (sec[k] < 0) chk_b("fan off", 1'b0, relays.comp_fan);
      else if (sec[k] == 0) chk_b("fan now", 1'b1, n <= 3);
      else chk_b("fan delay", 1'b1, n >= lo && n <= hi);
    end
    frz_def = 1'b1;
    frg_def = 1'b1;
    tick(2);
    chk_b("frz heater", 1'b0, relays.freezer_defrost);
    chk_b("frg heater", 1'b0, relays.fridge_defrost);
    comp_req = 1'b0;
    tick(2);
    chk_b("comp off", 1'b0, relays.compressor);
    chk_b("frz heater on", 1'b1, relays.freezer_defrost);
    chk_b("frg heater on", 1'b1, relays.fridge_defrost);
    frz_def = 1'b0;
    frg_def = 1'b0;
  endtask : t_fan

  task automatic t_blink();
    temps.freezer = 8'sd1;
    temps.fridge = 8'sd16;
    tick(BLINK_SEC * TDIV - 40);
    chk_b("frz blink early", 1'b0, frz_blink);
    tick(60);
    chk_b("frz blink", 1'b1, frz_blink);
    chk_b("frg blink", 1'b1, frg_blink);
    def_start = 1'b1;
    tick(1);
    def_start = 1'b0;
    tick(4);
    chk_b("frz hush", 1'b0, frz_blink);
    chk_v("frz set shown", 9'(frz_set), frz_shown);
    chk_v("frg set shown", 9'(frg_set), frg_shown);
    tick(BLINK_SEC * TDIV + 100);
    chk_b("frg still hushed", 1'b0, frg_blink);
  endtask : t_blink

  initial begin
    do_reset(10);
    t_straps();
    t_doors();
    t_fan();
    t_blink();
    summarize();
  end
endmodule : adfr_ctrl_tb

/* adfr_disp_chan.sv */
// One compartment display channel: stepping, clamping and warm blink.
// Assumes a one-second tick from the parent on the same clock.
`timescale 1ns/1ps
module adfr_disp_chan import adfr_pkg::*; #(
  parameter logic signed [7:0] SHOW_MIN = FRZ_SHOW_MIN,
  parameter logic signed [7:0] SHOW_MAX = FRZ_SHOW_MAX,
  parameter logic signed [7:0] WARM_LIMIT = FRZ_WARM_LIMIT,
  parameter int unsigned STEP_DELAY_SEC = STEP_DELAY_SEC_DEF
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic tick_i,
  input wire logic door_open_i,
  input wire logic defrost_start_i,
  input wire logic signed [7:0] actual_i,
  input wire logic signed [7:0] setpoint_i,
  output logic signed [7:0] shown_o,
  output logic show_actual_o,
  output logic blink_o
);
  if (SHOW_MIN > SHOW_MAX) begin : g_bad_range
    $error("adfr_disp_chan: bad show range");
  end
  if (STEP_DELAY_SEC < 1) begin : g_bad_step
    $error("adfr_disp_chan: step delay zero");
  end

  logic signed [7:0] shown_q;
  logic signed [7:0] target;
  logic [15:0] step_cnt_q;
  logic [15:0] warm_cnt_q;
  logic [15:0] hold_cnt_q;
  logic blink_q;
  logic act_mode_q;

  always_comb begin
    target = actual_i;
    if (target < SHOW_MIN) target = SHOW_MIN;
    if (target > SHOW_MAX) target = SHOW_MAX;
  end

  // Step the shown value one degree per delay toward its goal
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      shown_q <= 8'sh00;
      step_cnt_q <= 16'h0000;
      act_mode_q <= 1'b0;
    end else if (defrost_start_i) begin
      shown_q <= setpoint_i;
      act_mode_q <= 1'b0;
      step_cnt_q <= 16'h0000;
    end else if (door_open_i) begin
      act_mode_q <= 1'b1;
      if (tick_i) begin
        if (step_cnt_q >= 16'(STEP_DELAY_SEC - 1)) begin
          step_cnt_q <= 16'h0000;
          if (shown_q < target) shown_q <= shown_q + 8'sd1;
        end else begin
          step_cnt_q <= step_cnt_q + 16'h0001;
        end
      end
    end else if (act_mode_q) begin
      if (tick_i) begin
        if (step_cnt_q >= 16'(STEP_DELAY_SEC - 1)) begin
          step_cnt_q <= 16'h0000;
          if (shown_q > setpoint_i && shown_q > target) begin
            shown_q <= shown_q - 8'sd1;
          end else if (shown_q <= setpoint_i) begin
            shown_q <= setpoint_i;
            act_mode_q <= 1'b0;
          end
        end else begin
          step_cnt_q <= step_cnt_q + 16'h0001;
        end
      end
    end else begin
      shown_q <= setpoint_i;
      step_cnt_q <= 16'h0000;
    end
  end

  // Warm timer; the defrost hold blanks it so blink restarts from scratch
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      hold_cnt_q <= 16'h0000;
    end else if (defrost_start_i) begin
      hold_cnt_q <= 16'(DEFROST_HOLD_SEC);
    end else if (tick_i && hold_cnt_q != 16'h0000) begin
      hold_cnt_q <= hold_cnt_q - 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i || defrost_start_i || hold_cnt_q != 16'h0000) begin
      warm_cnt_q <= 16'h0000;
      blink_q <= 1'b0;
    end else if (actual_i <= WARM_LIMIT) begin
      warm_cnt_q <= 16'h0000;
      blink_q <= 1'b0;
    end else if (tick_i) begin
      if (warm_cnt_q >= 16'(BLINK_SEC - 1)) begin
        blink_q <= 1'b1;
      end else begin
        warm_cnt_q <= warm_cnt_q + 16'h0001;
      end
    end
  end

  assign shown_o = shown_q;
  assign show_actual_o = act_mode_q;
  assign blink_o = blink_q;
endmodule : adfr_disp_chan

/* adfr_env.sv */
// Door switches and option straps as the controller pins see them.
// Assumes door states and strap codes come from the bench.
`timescale 1ns/1ps
module adfr_env (
  input wire logic freezer_open_i,
  input wire logic fridge_open_i,
  input wire logic [2:0] frz_code_i,
  input wire logic [2:0] frg_code_i,
  output logic freezer_door_n_o,
  output logic fridge_door_n_o,
  output logic [5:0] straps_o
);
  // An open door closes the switch contact and pulls the pin low
  assign freezer_door_n_o = !freezer_open_i;
  assign fridge_door_n_o = !fridge_open_i;
  // Fitted diode reads high; the first strap is the top bit
  assign straps_o = {frz_code_i, frg_code_i};
endmodule : adfr_env

/* adfr_pkg.sv */
// Package for the appliance display, fan and relay controller.
// Assumes a 100 MHz system clock; temperatures are signed whole degrees C.
package adfr_pkg;
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned TICK_CYCLES = CLK_HZ;
  localparam int unsigned BLINK_MIN = 10;
  localparam int unsigned BLINK_SEC = BLINK_MIN * 60;
  localparam int unsigned DEFROST_HOLD_HR = 2;
  localparam int unsigned DEFROST_HOLD_SEC = DEFROST_HOLD_HR * 3600;
  localparam int unsigned FAN_LONG_MIN = 9;
  localparam int unsigned FAN_MID_MIN = 6;
  localparam int unsigned FAN_SHORT_MIN = 3;
  localparam int unsigned FAN_LONG_SEC = FAN_LONG_MIN * 60;
  localparam int unsigned FAN_MID_SEC = FAN_MID_MIN * 60;
  localparam int unsigned FAN_SHORT_SEC = FAN_SHORT_MIN * 60;
  localparam int unsigned STEP_DELAY_SEC_DEF = 60;
  localparam int unsigned BLINK_HALF_TICKS = 1;
  localparam logic signed [7:0] FRZ_SHOW_MIN = -8'sd35;
  localparam logic signed [7:0] FRZ_SHOW_MAX = 8'sd30;
  localparam logic signed [7:0] FRG_SHOW_MIN = -8'sd9;
  localparam logic signed [7:0] FRG_SHOW_MAX = 8'sd9;
  localparam logic signed [7:0] FRZ_WARM_LIMIT = 8'sd0;
  localparam logic signed [7:0] FRG_WARM_LIMIT = 8'sd15;
  localparam logic signed [7:0] AMB_FAN_OFF_MAX = 8'sd5;
  localparam logic signed [7:0] AMB_LONG_MAX = 8'sd10;
  localparam logic signed [7:0] AMB_MID_MAX = 8'sd15;
  localparam logic signed [7:0] AMB_SHORT_MAX = 8'sd21;
  // Shift in half degrees, indexed by the strap code
  localparam logic signed [3:0] SHIFT_REF = 4'sd0;
  localparam logic signed [3:0] SHIFT_M05 = -4'sd1;
  localparam logic signed [3:0] SHIFT_M10 = -4'sd2;
  localparam logic signed [3:0] SHIFT_M20 = -4'sd4;
  localparam logic signed [3:0] SHIFT_M30 = -4'sd6;
  localparam logic signed [3:0] SHIFT_P10 = 4'sd2;
  localparam logic signed [3:0] SHIFT_P20 = 4'sd4;
  localparam logic signed [3:0] SHIFT_P30 = 4'sd6;

  typedef struct packed {
    logic signed [7:0] freezer;
    logic signed [7:0] fridge;
    logic signed [7:0] ambient;
  } adfr_temps_t;

  typedef struct packed {
    logic compressor;
    logic comp_fan;
    logic freezer_defrost;
    logic fridge_defrost;
    logic freezer_lamp;
    logic fridge_lamp;
  } adfr_relays_t;

  typedef enum logic [2:0] {
    ADFR_FAN_IDLE = 3'b001,
    ADFR_FAN_WAIT = 3'b010,
    ADFR_FAN_ON = 3'b100
  } adfr_fan_state_t;
endpackage : adfr_pkg
